/* File: asrm_regs.svh */
`ifndef ASRM_REGS_SVH
`define ASRM_REGS_SVH
// Contract
// - Readback select bit 5 of config 2 set: SDO shifts SAR results.
// - In SAR readback writes still work, register reads are ignored.
// - SAR readback ends when bit 5 is written back to zero or on a reset.
// - Checksum off: SAR frame is header 0010 plus twelve result bits.
// - Checksum on: 24 clocks, header, twelve result bits, eight CRC.
// - Config 3 bit 4 set: SDO carries sigma-delta data, reads ignored.
// - Sigma-delta 64-bit word continues across byte-multiple frames.
// - SDI high on 64 consecutive SCLK clocks performs software reset.
// - SDO source priority: SAR, then sigma-delta, then registers.
// - Checksum on: eight-bit CRC appended to SAR and register frames.
// - Every checksum uses generator polynomial x^8 + x^2 + x + 1.
// - SDI bits are captured on the rising edge of SCLK.

// ****************************************************************
// Register addresses and fields
// ****************************************************************
`define ASRM_CFG2_ADDR 7'h12
`define ASRM_CFG3_ADDR 7'h13
`define ASRM_SAR_SEL_BIT 5
`define ASRM_SD_SEL_BIT 4
`define ASRM_CRC_EN_BIT 0

// ****************************************************************
// Frame constants
// ****************************************************************
`define ASRM_SAR_HDR 4'h2
`define ASRM_REG_HDR 8'h20
`define ASRM_CRC_POLY 8'h07
`define ASRM_CRC_INIT 8'h00
`define ASRM_FRAME_PLAIN 5'h10
`define ASRM_FRAME_CRC 5'h18
`define ASRM_RD_BYTE_AT 5'h08
`define ASRM_RST_ONES 7'h40
`endif

/* File: asrm_pkg.sv */
`default_nettype none
`include "asrm_regs.svh"
package asrm_pkg;
	// SDO source of the serial port.
	typedef enum logic [1:0] {ASRM_SRC_REG, ASRM_SRC_SD, ASRM_SRC_SAR} asrm_src_t;

	// One register write handed to the register file.
	typedef struct packed {
		logic [6:0] addr;
		logic [7:0] data;
	} asrm_wr_t;

	// Whole state of the serial port.
	typedef struct packed {
		logic [2:0] cs_s;
		logic [2:0] ck_s;
		logic [2:0] di_s;
		logic sel;
		logic sclk;
		logic sdi;
		logic sar_sel;
		logic sd_sel;
		logic crc_en;
		logic [4:0] cnt;
		logic [23:0] in_sh;
		logic [7:0] crc_in;
		logic [7:0] crc_out;
		logic [23:0] out_sh;
		logic [63:0] sd_word;
		logic [5:0] sd_ptr;
		logic sd_full;
		logic [6:0] ones;
		logic [11:0] sar_hold;
		logic sdo;
		logic wr_stb;
		asrm_wr_t wr;
		logic rd_stb;
		logic crc_err;
		logic sw_rst;
	} asrm_state_t;

	// SAR wins over sigma-delta, which wins over the register map.
	function automatic asrm_src_t asrm_src_sel(input logic sar, input logic sd);
		if (sar)
			return ASRM_SRC_SAR;
		else if (sd)
			return ASRM_SRC_SD;
		return ASRM_SRC_REG;
	endfunction : asrm_src_sel

	// One serial CRC step, MSB first.
	function automatic logic [7:0] asrm_crc_step(input logic [7:0] c,
		input logic b);
		logic fb;
		fb = c[7] ^ b;
		return {c[6:0], 1'b0} ^ (fb ? `ASRM_CRC_POLY : 8'h00);
	endfunction : asrm_crc_step
endpackage : asrm_pkg
`default_nettype wire

/* File: asrm_fifo.sv */
`timescale 1ns/1ns
`default_nettype none
module asrm_fifo #(
	parameter int WIDTH = 64,
	parameter int DEPTH = 32
)
(
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);
	import asrm_pkg::*;
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW:0] wp;
		logic [AW:0] rp;
	} asrm_fifo_st_t;

	asrm_fifo_st_t q;
	asrm_fifo_st_t d;
	logic [AW:0] count;
	logic push;
	logic pop;

	// Pointer wrap relies on a power-of-two depth.
	if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1)
	begin : g_bad_size
		$error("asrm_fifo: DEPTH must be a power of two, at least 2");
	end

	// Honest flags: one spare pointer bit tells full from empty.
	assign count = q.wp - q.rp;
	assign in_ready_o = (count != (AW+1)'(DEPTH));
	assign out_valid_o = (count != '0);
	assign out_data_o = q.mem[q.rp[AW-1:0]];
	assign push = in_valid_i && in_ready_o;
	assign pop = out_valid_o && out_ready_i;

	// Next state.
	always_comb
	begin
		d = q;
		if (push)
		begin
			d.mem[q.wp[AW-1:0]] = in_data_i;
			d.wp = q.wp + 1'b1;
		end
		if (pop)
			d.rp = q.rp + 1'b1;
	end

	// State register.
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
			q <= '0;
		else
			q <= d;
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (reset_i);

	AST_FIFO_NOT_OVER: assert property (count <= (AW+1)'(DEPTH))
		else $error("fifo count above depth");
	AST_FIFO_PUSH: assert property (push && !pop |=> count == $past(count) + 1'b1)
		else $error("fifo push lost");
endmodule : asrm_fifo
`default_nettype wire

/* File: asrm_spi.sv */
`timescale 1ns/1ns
`default_nettype none
`include "asrm_regs.svh"
module asrm_spi #(
	parameter int SD_DEPTH = 32
)
(
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic cs_n_i,
	input wire logic sclk_i,
	input wire logic sdi_i,
	output logic sdo_o,
	output logic sdo_oe_o,
	input wire logic sar_valid_i,
	input wire logic [11:0] sar_data_i,
	input wire logic sd_valid_i,
	output logic sd_ready_o,
	input wire logic [63:0] sd_data_i,
	output logic reg_wr_stb_o,
	output asrm_pkg::asrm_wr_t reg_wr_o,
	output logic [6:0] reg_rd_addr_o,
	output logic reg_rd_stb_o,
	input wire logic [7:0] reg_rd_data_i,
	output logic sar_mode_o,
	output logic sd_mode_o,
	output logic crc_en_o,
	output logic crc_err_o,
	output logic sw_rst_o
);
	import asrm_pkg::*;

	asrm_state_t q;
	asrm_state_t d;
	asrm_src_t src;
	logic rise;
	logic fall;
	logic sel_on;
	logic sel_off;
	logic reload;
	logic done;
	logic crc_ok;
	logic [4:0] flen;
	logic [15:0] cmd;
	logic fifo_valid;
	logic fifo_pop;
	logic [63:0] fifo_data;

	// ****************************************************************
	// Sigma-delta word buffer
	// ****************************************************************
	// Words wait here so the converter side can run ahead of the master.
	asrm_fifo #(
		.WIDTH(64),
		.DEPTH(SD_DEPTH)
	) u_sd_fifo (
		.clk_i(clk_i),
		.reset_i(reset_i),
		.in_valid_i(sd_valid_i),
		.in_ready_o(sd_ready_o),
		.in_data_i(sd_data_i),
		.out_valid_o(fifo_valid),
		.out_ready_i(fifo_pop),
		.out_data_o(fifo_data)
	);

	// ****************************************************************
	// Serial port engine
	// ****************************************************************
	// Pins pass three flops; a level counts once the last two agree.
	always_comb
	begin
		d = q;
		cmd = 16'h0000;
		crc_ok = 1'b0;
		reload = 1'b0;
		fifo_pop = 1'b0;
		d.wr_stb = 1'b0;
		d.rd_stb = 1'b0;
		d.sw_rst = 1'b0;
		d.crc_err = 1'b0;
		d.cs_s = {q.cs_s[1:0], ~cs_n_i};
		d.ck_s = {q.ck_s[1:0], sclk_i};
		d.di_s = {q.di_s[1:0], sdi_i};
		if (q.cs_s[1] == q.cs_s[2])
			d.sel = q.cs_s[2];
		if (q.ck_s[1] == q.ck_s[2])
			d.sclk = q.ck_s[2];
		if (q.di_s[1] == q.di_s[2])
			d.sdi = q.di_s[2];
		sel_on = !q.sel && d.sel;
		sel_off = q.sel && !d.sel;
		rise = q.sel && !q.sclk && d.sclk;
		fall = q.sel && q.sclk && !d.sclk;
		flen = q.crc_en ? `ASRM_FRAME_CRC : `ASRM_FRAME_PLAIN;
		done = rise && (q.cnt + 5'h01 == flen);
		src = asrm_src_sel(q.sar_sel, q.sd_sel);
		if (sar_valid_i)
			d.sar_hold = sar_data_i;
		// Frame start with an idle bit counter refreshes the SAR result.
		if (sel_on && q.cnt == 5'h00)
			reload = 1'b1;

		// Sigma-delta stream: the pointer survives deselect, so a word
		// may be split over up to eight byte frames.
		if (src == ASRM_SRC_SD && !q.sd_full && (sel_on || fall))
		begin
			d.sd_word = fifo_valid ? fifo_data : 64'h0000_0000_0000_0000;
			fifo_pop = fifo_valid;
			d.sd_full = 1'b1;
		end
		else if (src == ASRM_SRC_SD && fall && q.sd_full && q.sd_ptr != 6'h00)
			d.sd_word = {q.sd_word[62:0], 1'b0};

		// Register and SAR frames move out on the falling edge.
		if (fall && q.cnt != 5'h00 && src != ASRM_SRC_SD)
		begin
			d.out_sh = {q.out_sh[22:0], 1'b0};
			if (q.cnt <= `ASRM_FRAME_PLAIN)
				d.crc_out = asrm_crc_step(q.crc_out, q.out_sh[23]);
			// Only the register source answers a read; in readback
			// modes the harmless read command has no effect.
			if (q.cnt == `ASRM_RD_BYTE_AT && src == ASRM_SRC_REG && q.in_sh[7])
			begin
				d.out_sh[23:16] = reg_rd_data_i;
				d.rd_stb = 1'b1;
			end
			if (q.cnt == `ASRM_FRAME_PLAIN)
				d.out_sh[23:16] = d.crc_out;
		end

		// SDI is taken on the rising edge only.
		if (rise)
		begin
			d.in_sh = {q.in_sh[22:0], q.sdi};
			if (q.cnt < `ASRM_FRAME_PLAIN)
				d.crc_in = asrm_crc_step(q.crc_in, q.sdi);
			d.cnt = q.cnt + 5'h01;
			d.ones = q.sdi ? q.ones + 7'h01 : 7'h00;
			if (src == ASRM_SRC_SD)
			begin
				d.sd_ptr = q.sd_ptr + 6'h01;
				if (&q.sd_ptr)
					d.sd_full = 1'b0;
			end
		end

		// Command complete: writes go through in every source mode.
		if (done)
		begin
			cmd = q.crc_en ? d.in_sh[23:8] : d.in_sh[15:0];
			crc_ok = !q.crc_en || d.in_sh[7:0] == q.crc_in;
			d.cnt = 5'h00;
			reload = 1'b1;
			if (!crc_ok)
				d.crc_err = 1'b1;
			else if (!cmd[15])
			begin
				d.wr_stb = 1'b1;
				d.wr = '{addr: cmd[14:8], data: cmd[7:0]};
				if (cmd[14:8] == `ASRM_CFG2_ADDR)
					d.sar_sel = cmd[`ASRM_SAR_SEL_BIT];
				if (cmd[14:8] == `ASRM_CFG3_ADDR)
				begin
					d.sd_sel = cmd[`ASRM_SD_SEL_BIT];
					d.crc_en = cmd[`ASRM_CRC_EN_BIT];
				end
			end
		end

		// A byte cut short by deselect is dropped; whole bytes carry on.
		if (sel_off && q.cnt[2:0] != 3'h0)
		begin
			d.cnt = 5'h00;
			reload = 1'b1;
		end
		if (!q.sel)
			d.ones = 7'h00;

		// Sixty-four high bits in a row restore the reset modes.
		if (rise && q.sdi && q.ones == `ASRM_RST_ONES - 7'h01)
		begin
			d.sw_rst = 1'b1;
			d.ones = 7'h00;
			d.sar_sel = 1'b0;
			d.sd_sel = 1'b0;
			d.crc_en = 1'b0;
			d.cnt = 5'h00;
			d.sd_ptr = 6'h00;
			d.sd_full = 1'b0;
			d.wr_stb = 1'b0;
			reload = 1'b1;
		end

		// A new frame is built from the source that will be in force.
		if (reload)
		begin
			d.crc_in = `ASRM_CRC_INIT;
			d.crc_out = `ASRM_CRC_INIT;
			if (asrm_src_sel(d.sar_sel, d.sd_sel) == ASRM_SRC_SAR)
				d.out_sh = {`ASRM_SAR_HDR, d.sar_hold, 8'h00};
			else
				d.out_sh = {`ASRM_REG_HDR, 16'h0000};
		end
		if (asrm_src_sel(d.sar_sel, d.sd_sel) == ASRM_SRC_SD)
			d.sdo = d.sd_word[63];
		else
			d.sdo = d.out_sh[23];
	end

	// State register.
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			q <= '0;
			q.out_sh <= {`ASRM_REG_HDR, 16'h0000};
			q.sdo <= 1'b0;
		end
		else
			q <= d;
	end

	// Outputs straight from state flops.
	assign sdo_o = q.sdo;
	assign sdo_oe_o = q.sel;
	assign reg_wr_stb_o = q.wr_stb;
	assign reg_wr_o = q.wr;
	assign reg_rd_addr_o = q.in_sh[6:0];
	assign reg_rd_stb_o = q.rd_stb;
	assign sar_mode_o = q.sar_sel;
	assign sd_mode_o = q.sd_sel;
	assign crc_en_o = q.crc_en;
	assign crc_err_o = q.crc_err;
	assign sw_rst_o = q.sw_rst;

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (reset_i);

	sequence s_idle;
		!q.sel;
	endsequence
	sequence s_last_high;
		rise && q.sdi && q.ones == 7'h3F;
	endsequence
	sequence s_reset_done;
		q.sw_rst && q.cnt == 5'h00 && !q.sar_sel && !q.sd_sel;
	endsequence
	// A write frame that is not overtaken by a software reset in the
	// same cycle.
	sequence s_plain_write;
		done && !q.crc_en && !q.in_sh[14]
			&& !(rise && q.sdi && q.ones == 7'h3F);
	endsequence

	AST_SAR_HDR: assert property (q.cnt == 5'h00 && src == ASRM_SRC_SAR |-> q.out_sh[23:20] == 4'h2)
		else $error("SAR frame header wrong");
	AST_REG_HDR: assert property (q.cnt == 5'h00 && src == ASRM_SRC_REG |-> q.out_sh[23:16] == 8'h20)
		else $error("register frame header wrong");
	AST_RD_ONLY_REG: assert property (q.rd_stb |-> src == ASRM_SRC_REG)
		else $error("read served in readback mode");
	AST_WR_TAKEN: assert property (s_plain_write |=> q.wr_stb)
		else $error("write not taken");
	AST_SAR_EXIT: assert property (q.wr_stb && q.wr.addr == 7'h12 |-> q.sar_sel == q.wr.data[5])
		else $error("SAR select not following write");
	AST_CRC_BAD: assert property (rise && q.crc_en && q.cnt == 5'h17 && {q.in_sh[6:0], q.sdi} != q.crc_in |=> q.crc_err && !q.wr_stb)
		else $error("bad checksum not refused");
	AST_FRAME_LEN: assert property (q.cnt < (q.crc_en ? 5'h18 : 5'h10))
		else $error("frame counter past frame length");
	AST_SD_HOLD: assert property (s_idle |=> $stable(q.sd_ptr))
		else $error("sigma-delta pointer moved while idle");
	AST_ONES_CLR: assert property (s_idle |=> q.ones == 7'h00)
		else $error("high count kept over deselect");
	AST_SW_RST: assert property (s_last_high |=> s_reset_done ##1 !q.sw_rst)
		else $error("software reset missing");
	AST_SAMPLE_RISE: assert property ($changed(q.in_sh) |-> $past(rise))
		else $error("SDI taken off the rising edge");
endmodule : asrm_spi
`default_nettype wire

/* File: asrm_master.sv */
`timescale 1ns/1ns
`default_nettype none
module asrm_master
(
	input wire logic clk_i,
	input wire logic sdo_i,
	output logic cs_n_o,
	output logic sclk_o,
	output logic sdi_o
);
	// Idle: deselected, clock parked low for mode 0.
	initial
	begin
		cs_n_o = 1'b1;
		sclk_o = 1'b0;
		sdi_o = 1'b0;
	end

	// One frame of n bits, MSB first. Halves of eight cycles keep well
	// above the two-cycle minimum that the input filters need.
	task automatic frame(input int n, input logic [63:0] din,
		output logic [63:0] dout);
		dout = '0;
		@(posedge clk_i);
		cs_n_o <= 1'b0;
		for (int i = n - 1; i >= 0; i--)
		begin
			sdi_o <= din[i];
			repeat (8) @(posedge clk_i);
			sclk_o <= 1'b1;
			dout = {dout[62:0], sdo_i};
			repeat (8) @(posedge clk_i);
			sclk_o <= 1'b0;
		end
		repeat (8) @(posedge clk_i);
		cs_n_o <= 1'b1;
		// A released line must not keep its last value.
		sdi_o <= ~sdi_o;
		repeat (8) @(posedge clk_i);
	endtask : frame
endmodule : asrm_master
`default_nettype wire

/* File: asrm_tb.sv */
`timescale 1ns/1ns
`default_nettype none
module tb;
	import asrm_pkg::*;
	localparam int DEPTH = 4;
	logic clk_i = 1'b0;
	logic reset_i = 1'b1;
	logic cs_n, sclk, sdi, sdo, sdo_oe, sar_valid = 1'b0, sd_valid = 1'b0;
	logic sd_ready, wr_stb, rd_stb, sar_mode, sd_mode, crc_en, crc_err;
	logic sw_rst;
	logic [11:0] sar_data = 12'h000;
	logic [63:0] sd_data = 64'h0000_0000_0000_0000;
	logic [6:0] rd_addr;
	logic [7:0] rd_data;
	asrm_wr_t wr, last_wr;
	int n_fail = 0, checked = 0, n_wr = 0, n_rd = 0, n_err = 0, n_rst = 0;

	// ************************************************************
	// Clock, device and master
	// ************************************************************
	// Free-running 250 MHz clock.
	always #2 clk_i = ~clk_i;

	// Register file stand-in: data depends on the address only.
	assign rd_data = 8'h3c ^ {1'b0, rd_addr};

	asrm_spi #(.SD_DEPTH(DEPTH)) i_asrm_spi (.clk_i(clk_i),
		.reset_i(reset_i), .cs_n_i(cs_n), .sclk_i(sclk), .sdi_i(sdi),
		.sdo_o(sdo), .sdo_oe_o(sdo_oe), .sar_valid_i(sar_valid),
		.sar_data_i(sar_data), .sd_valid_i(sd_valid),
		.sd_ready_o(sd_ready), .sd_data_i(sd_data),
		.reg_wr_stb_o(wr_stb), .reg_wr_o(wr), .reg_rd_addr_o(rd_addr),
		.reg_rd_stb_o(rd_stb), .reg_rd_data_i(rd_data),
		.sar_mode_o(sar_mode), .sd_mode_o(sd_mode), .crc_en_o(crc_en),
		.crc_err_o(crc_err), .sw_rst_o(sw_rst));

	asrm_master i_asrm_master (.clk_i(clk_i), .sdo_i(sdo), .cs_n_o(cs_n),
		.sclk_o(sclk), .sdi_o(sdi));

	// Pulse counters, so scenarios can judge strobes after a frame.
	always @(posedge clk_i)
	begin
		if (!reset_i)
		begin
			if (wr_stb === 1'b1)
				last_wr = wr;
			n_wr += (wr_stb === 1'b1);
			n_rd += (rd_stb === 1'b1);
			n_err += (crc_err === 1'b1);
			n_rst += (sw_rst === 1'b1);
		end
	end

	// ************************************************************
	// Shared tasks
	// ************************************************************
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		checked++;
		if (got !== exp)
		begin
			n_fail++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// Bench's own checksum, MSB first, init zero.
	function automatic logic [7:0] crc8(input logic [15:0] d);
		logic [7:0] c;
		c = 8'h00;
		for (int i = 15; i >= 0; i--)
			c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
		return c;
	endfunction : crc8

	function automatic logic [63:0] word(input int k);
		return 64'h0123_4567_89ab_cdef + 64'(k) * 64'h1111_1111_1111_1111;
	endfunction : word

	task automatic xfer(input int n, input logic [63:0] din, exp);
		logic [63:0] d;
		i_asrm_master.frame(n, din, d);
		chk(d, exp);
	endtask : xfer

	task automatic sar_pulse(input logic [11:0] v);
		@(posedge clk_i);
		sar_valid <= 1'b1;
		sar_data <= v;
		@(posedge clk_i);
		sar_valid <= 1'b0;
	endtask : sar_pulse

	// Collects one 64-bit word in frames of s bits with ignored reads.
	task automatic sd_read(input int s, output logic [63:0] got);
		logic [63:0] d;
		got = '0;
		for (int j = 0; j < 64 / s; j++)
		begin
			i_asrm_master.frame(s, 64'h8000_8000_8000_8000 >> (64 - s), d);
			got = (got << s) | d;
		end
	endtask : sd_read

	// ************************************************************
	// Scenarios
	// ************************************************************
	task automatic t_reg();
		int r;
		r = n_rd;
		chk(sdo_oe, 0);
		xfer(16, 64'h8500, {8'h20, 8'h39});
		chk(n_rd - r, 1);
		xfer(16, 64'h1220, 64'h2000);
		chk(last_wr, {7'h12, 8'h20});
		chk(sar_mode, 1);
	endtask : t_reg

	task automatic t_sar();
		int r, w;
		logic [63:0] d;
		sar_pulse(12'habc);
		r = n_rd;
		xfer(16, 64'h8000, 64'h2abc);
		chk(n_rd - r, 0);
		w = n_wr;
		i_asrm_master.frame(16, 64'h1310, d);
		chk(n_wr - w, 1);
		chk(sd_mode, 1);
		sar_pulse(12'h5e7);
		xfer(8, 64'h80, 64'h25);
		xfer(8, 64'h00, 64'he7);
		i_asrm_master.frame(16, 64'h1200, d);
		chk(sar_mode, 0);
	endtask : t_sar

	task automatic t_sd();
		int m, r;
		logic [63:0] got;
		m = 0;
		r = n_rd;
		// Keep offering words; the full buffer stalls the producer.
		@(posedge clk_i);
		sd_valid <= 1'b1;
		sd_data <= word(0);
		repeat (10)
		begin
			@(negedge clk_i);
			if (sd_ready === 1'b1)
				m++;
			@(posedge clk_i);
			sd_data <= word(m);
		end
		sd_valid <= 1'b0;
		chk(m >= DEPTH && m <= DEPTH + 1, 1);
		chk(sd_ready, 0);
		// The word latched when the mode came on met an empty buffer.
		sd_read(64, got);
		chk(got, 0);
		for (int k = 0; k < m; k++)
		begin
			sd_read(64 >> (k % 4), got);
			chk(got, word(k));
		end
		sd_read(64, got);
		chk(got, 0);
		chk(n_rd - r, 0);
		@(negedge clk_i);
		chk(sd_ready, 1);
		i_asrm_master.frame(16, 64'h1301, got);
		chk({sd_mode, crc_en}, 2'b01);
	endtask : t_sd

	task automatic t_crc();
		int e, w;
		logic [63:0] d;
		e = n_err;
		w = n_wr;
		i_asrm_master.frame(24, {16'h1220, ~crc8(16'h1220)}, d);
		chk(n_err - e, 1);
		chk(n_wr - w, 0);
		chk(sar_mode, 0);
		xfer(24, {16'h1220, crc8(16'h1220)}, {16'h2000, crc8(16'h2000)});
		chk(sar_mode, 1);
		sar_pulse(12'h9c3);
		xfer(24, {16'h8000, crc8(16'h8000)}, {16'h29c3, crc8(16'h29c3)});
	endtask : t_crc

	task automatic t_rst();
		int q;
		logic [63:0] d;
		q = n_rst;
		i_asrm_master.frame(32, '1, d);
		i_asrm_master.frame(32, '1, d);
		chk(n_rst - q, 0);
		i_asrm_master.frame(64, '1, d);
		chk(n_rst - q, 1);
		chk({sar_mode, sd_mode, crc_en}, 0);
	endtask : t_rst

	task automatic complete_run();
		$display("checks %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : complete_run

	// Main sequence; four spare edges let the input filters refill.
	initial
	begin
		repeat (12) @(posedge clk_i);
		reset_i <= 1'b0;
		repeat (4) @(posedge clk_i);
		t_reg();
		t_sar();
		t_sd();
		t_crc();
		t_rst();
		complete_run();
	end

	// Watchdog, about three times the expected run length.
	initial
	begin
		repeat (40000) @(posedge clk_i);
		n_fail++;
		complete_run();
	end
endmodule : tb
`default_nettype wire
